// ===== hdl/external_interrupt_pin_latch.sv
// External interrupt pin latch with mask, sensitivity select and software acknowledge.
//
// Overview of operation
// RL1 - A falling edge on the active-low pin sets the request latch.
// RL2 - A vector fetch acknowledge clears the latch that caused that fetch.
// RL3 - Writing one to the acknowledge field clears the latch.
// RL4 - Reset clears the latch and sensitivity select, even with the pin low.
// RL5 - Out of reset the pin is edge sensitive; software may add level sensitivity.
// RL6 - In edge-only mode any acknowledge clears the latch at once, whatever the pin.
// RL7 - In edge-and-level mode clearing needs both an acknowledge and a high pin.
// RL8 - In edge-and-level mode the request stays pending while the pin is low.
// RL9 - A set mask field keeps the latched request from the priority logic.
// RL10 - The pending flag reads one while pending, independent of the mask.
// RL11 - The acknowledge field is write-only, reads zero, and is cleared by reset.
// RL12 - A falling edge after a software acknowledge sets the latch again.
// RL13 - A taken request loads the program counter from the two fixed vector locations.
// RL14 - With break-clear enabled, acknowledges in break clear the latch for good.
// RL15 - With break-clear disabled, acknowledges in break leave the flags unchanged; the code blocks only the software one, a vector fetch still clears.
// RL16 - The mask field is read/write, one disables, zero enables, reset clears it.
// RL17 - The sensitivity field is read/write: one edge and level, zero edge only.
// RL18 - The current pin level is offered for the branch-on-pin instructions.
// RL19 - The processor global interrupt mask also blocks this request.
// RL20 - Software should mask requests in its routine when using level sensitivity.
// RL21 - The pin is synchronised and an edge is a high then a low sample.
`timescale 1ns/1ps
`default_nettype none

module external_interrupt_pin_latch #(
  parameter int ADDR_W = ext_int_pkg::ADDR_W,
  parameter int DATA_W = ext_int_pkg::DATA_W
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              irq_n_in,
  input  wire logic              vector_fetch_in,
  input  wire logic              break_state_in,
  input  wire logic              break_clear_enable_in,
  input  wire logic              global_int_mask_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output var  logic [DATA_W-1:0] reg_rdata_out,
  output logic                   int_request_out,
  output var  logic              pin_level_out,
  output var  logic [15:0]       vector_high_addr_out,
  output var  logic [15:0]       vector_low_addr_out
);

  ext_int_pkg::bus_req_t     req;
  ext_int_pkg::ctrl_t        ctrl;
  ext_int_pkg::ctrl_t        next_ctrl;
  ext_int_pkg::latch_state_t state;
  ext_int_pkg::latch_state_t next_state;

  logic              pin_sync_level;
  logic              pin_prev;
  logic              next_pin_prev;
  logic              next_pin_level;
  logic [2:0]        arm_shift;
  logic [2:0]        next_arm_shift;
  logic [DATA_W-1:0] next_rdata;
  logic [15:0]       next_vector_high;
  logic [15:0]       next_vector_low;

  logic reg_hit;
  logic reg_write;
  logic reg_read;
  logic sw_ack;
  logic any_ack;
  logic fall_edge;
  logic pin_high;
  logic level_request;
  logic pending;

  // RL21 pin synchronisation.
  pin_sync #(
    .RESET_LEVEL (ext_int_pkg::PIN_IDLE_LEVEL)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (irq_n_in),
    .sync_out   (pin_sync_level)
  );

  assign req.addr  = reg_addr_in;
  assign req.wdata = reg_wdata_in;
  assign req.wr    = reg_wr_in;
  assign req.rd    = reg_rd_in;

  assign reg_hit   = (req.addr == ext_int_pkg::STATUS_CONTROL_OFFSET);
  assign reg_write = req.wr && reg_hit;
  assign reg_read  = req.rd && reg_hit;

  // RL21 edge is high sample then low.
  // Edges wait until both samples are real, so a pin held low through reset never latches;
  // the price is that an edge in the first three cycles after reset is not seen.
  assign fall_edge = arm_shift[2] && pin_prev && !pin_sync_level;
  assign pin_high  = pin_sync_level;

  // RL3 software acknowledge strobe.
  // RL15 acknowledge blocked in break.
  // RL14 acknowledge allowed in break.
  assign sw_ack = reg_write && req.wdata[ext_int_pkg::ACK_BIT]
                  && (!break_state_in || break_clear_enable_in);

  // RL2 vector fetch acknowledge.
  assign any_ack = vector_fetch_in || sw_ack;

  // RL8 low level requests.
  assign level_request = ctrl.mode && !pin_sync_level;

  assign pending = (state != ext_int_pkg::LATCH_IDLE);

  // RL9 local mask gate.
  // RL19 global mask gate.
  assign int_request_out = pending && !ctrl.mask && !global_int_mask_in;

  // Edge history register.
  always_comb begin
    next_pin_prev  = pin_sync_level;
    next_pin_level = pin_sync_level;
    next_arm_shift = {arm_shift[1:0], 1'b1};
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_prev      <= ext_int_pkg::PIN_IDLE_LEVEL;
      pin_level_out <= ext_int_pkg::PIN_IDLE_LEVEL;
      arm_shift     <= '0;
    end else begin
      pin_prev      <= next_pin_prev;
      arm_shift     <= next_arm_shift;
      // RL18 pin level for branches.
      pin_level_out <= next_pin_level;
    end
  end

  // Control fields. Writes to mask and mode are not blocked in break; only the
  // acknowledge is, since only the flags need protecting while debugging.
  always_comb begin
    next_ctrl = ctrl;
    if (reg_write) begin
      // RL16 mask field write.
      next_ctrl.mask = req.wdata[ext_int_pkg::MASK_BIT];
      // RL17 sensitivity field write.
      next_ctrl.mode = req.wdata[ext_int_pkg::MODE_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // RL4 reset clears sensitivity.
      // RL5 edge-only after reset.
      ctrl.mode <= ext_int_pkg::MODE_RESET;
      ctrl.mask <= ext_int_pkg::MASK_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Request latch. An acknowledge in edge-and-level mode that comes while the pin
  // is still low parks in the acked state until the pin returns high or the mode is set back to edge-only.
  always_comb begin
    next_state = state;
    case (state)
      ext_int_pkg::LATCH_IDLE: begin
        if (level_request) begin
          next_state = ext_int_pkg::LATCH_SET;
        end
      end
      ext_int_pkg::LATCH_SET: begin
        if (any_ack) begin
          // RL6 edge-only clear at once.
          if (!ctrl.mode) begin
            next_state = ext_int_pkg::LATCH_IDLE;
          // RL7 acknowledge and pin high.
          end else if (pin_high) begin
            next_state = ext_int_pkg::LATCH_IDLE;
          end else begin
            next_state = ext_int_pkg::LATCH_ACKED;
          end
        end
      end
      ext_int_pkg::LATCH_ACKED: begin
        // RL7 pin returned high.
        if (pin_high || !ctrl.mode) begin
          next_state = ext_int_pkg::LATCH_IDLE;
        end
      end
      default: begin
        next_state = ext_int_pkg::LATCH_IDLE;
      end
    endcase
    // RL1 falling edge sets latch.
    // RL12 new edge after acknowledge.
    if (fall_edge) begin
      next_state = ext_int_pkg::LATCH_SET;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // RL4 reset clears latch.
      state <= ext_int_pkg::LATCH_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Read data, valid in the cycle after the read strobe only.
  always_comb begin
    next_rdata = '0;
    if (reg_read) begin
      // RL10 pending flag readback.
      next_rdata[ext_int_pkg::PENDING_BIT] = pending;
      // RL11 acknowledge reads zero.
      next_rdata[ext_int_pkg::ACK_BIT]     = 1'b0;
      next_rdata[ext_int_pkg::MASK_BIT]    = ctrl.mask;
      next_rdata[ext_int_pkg::MODE_BIT]    = ctrl.mode;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= ext_int_pkg::STATUS_CONTROL_RESET;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // Vector locations offered to the processor when it takes the request.
  always_comb begin
    next_vector_high = ext_int_pkg::VECTOR_HIGH_ADDR;
    next_vector_low  = ext_int_pkg::VECTOR_LOW_ADDR;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // RL13 fixed vector locations.
      vector_high_addr_out <= ext_int_pkg::VECTOR_HIGH_ADDR;
      vector_low_addr_out  <= ext_int_pkg::VECTOR_LOW_ADDR;
    end else begin
      vector_high_addr_out <= next_vector_high;
      vector_low_addr_out  <= next_vector_low;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking

  default disable iff (!rst_n_in);

  edge_sets_latch_a: assert property ( // RL1
    fall_edge |=> pending ##0 int_request_out == (!ctrl.mask && !global_int_mask_in)
  ) else $error("Falling edge did not set the request latch.");

  fetch_clears_a: assert property ( // RL2
    (pending && vector_fetch_in && !ctrl.mode && !fall_edge) |=> !pending
  ) else $error("Vector fetch did not clear the latch.");

  sw_ack_clears_a: assert property ( // RL3
    (pending && reg_write && req.wdata[ext_int_pkg::ACK_BIT] && !break_state_in
     && !ctrl.mode && !fall_edge) |=> !pending
  ) else $error("Software acknowledge did not clear the latch.");

  level_holds_a: assert property ( // RL8
    (pending && ctrl.mode && !pin_sync_level) |=> pending
  ) else $error("Request dropped while pin held low in level mode.");

  level_clear_both_a: assert property ( // RL7
    (state == ext_int_pkg::LATCH_ACKED && pin_high && !fall_edge) |=> !pending
  ) else $error("Acknowledged request not cleared when pin rose.");

  break_protect_a: assert property ( // RL15
    (state == ext_int_pkg::LATCH_SET && reg_write && break_state_in && !break_clear_enable_in
     && !vector_fetch_in) |=> pending
  ) else $error("Acknowledge during break changed the flags.");

  break_clear_a: assert property ( // RL14
    (pending && sw_ack && break_state_in && !ctrl.mode && !fall_edge)
    |=> !pending ##1 (pending -> $past(fall_edge || level_request))
  ) else $error("Break-clear acknowledge did not clear the latch for good.");

  mask_gate_a: assert property ( // RL9
    ctrl.mask |-> !int_request_out
  ) else $error("Masked request reached the priority logic.");

  global_mask_gate_a: assert property ( // RL19
    global_int_mask_in |-> !int_request_out
  ) else $error("Global mask did not block the request.");

  pending_read_a: assert property ( // RL10
    reg_read |=> reg_rdata_out[ext_int_pkg::PENDING_BIT] == $past(pending)
  ) else $error("Pending flag readback wrong.");

  ack_reads_zero_a: assert property ( // RL11
    req.rd |=> reg_rdata_out[ext_int_pkg::ACK_BIT] == 1'b0
  ) else $error("Acknowledge field read back non-zero.");

  ctrl_readback_a: assert property ( // RL16
    (reg_write ##1 reg_read) |=> reg_rdata_out[ext_int_pkg::MASK_BIT]
                                 == $past(req.wdata[ext_int_pkg::MASK_BIT], 2)
  ) else $error("Mask field did not read back as written.");

  pin_level_a: assert property ( // RL18
    arm_shift[0] |-> ##3 pin_level_out == $past(irq_n_in, 3)
  ) else $error("Pin level output does not follow the pin.");

endmodule : external_interrupt_pin_latch

`default_nettype wire

// ===== shared/ext_int_pkg.sv
// Package with the register map, field layout and types of the external interrupt latch.
`default_nettype none

package ext_int_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // The single status and control register.
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_OFFSET = 8'h00;

  // Field positions inside the status and control register.
  localparam int MODE_BIT    = 0;
  localparam int MASK_BIT    = 1;
  localparam int ACK_BIT     = 2;
  localparam int PENDING_BIT = 3;

  // Reset values.
  localparam logic [DATA_W-1:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic              MODE_RESET           = 1'b0;
  localparam logic              MASK_RESET           = 1'b0;
  localparam logic              PIN_IDLE_LEVEL       = 1'b1;

  // Locations of the two vector bytes loaded into the program counter.
  localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFA;
  localparam logic [15:0] VECTOR_LOW_ADDR  = 16'hFFFB;

  // Software-visible control fields.
  typedef struct packed {
    logic mask;
    logic mode;
  } ctrl_t;

  // One register port request as seen in a single cycle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  // Request latch states.
  typedef enum logic [1:0] {
    LATCH_IDLE,
    LATCH_SET,
    LATCH_ACKED
  } latch_state_t;

endpackage : ext_int_pkg

`default_nettype wire

// ===== hdl/pin_sync.sv
// Two-stage synchroniser for one asynchronous input level.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic stage_one;
  logic next_stage_one;
  logic next_sync;

  // The first stage feeds the second stage only, so a metastable value never fans out.
  always_comb begin
    next_stage_one = async_in;
    next_sync      = stage_one;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_one <= RESET_LEVEL;
      sync_out  <= RESET_LEVEL;
    end else begin
      stage_one <= next_stage_one;
      sync_out  <= next_sync;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== verification/irq_pin_source.sv
// Model of the external source that drives the interrupt pin.
`timescale 1ns/1ps
`default_nettype none

module irq_pin_source (
  input  wire logic low_req_in,
  output var  logic irq_n_out
);
  // The pin has a pull-up, so a released pin rests high, never at the last driven value.
  always_comb begin
    irq_n_out = low_req_in ? 1'b0 : 1'b1;
  end
endmodule : irq_pin_source

`default_nettype wire

// ===== verification/test_external_interrupt_pin_latch.sv
// Self-checking bench for the external interrupt pin latch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_external_interrupt_pin_latch;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        low_req    = 1'b0;
  logic        irq_n;
  logic        vfetch     = 1'b0;
  logic        brk        = 1'b0;
  logic        bce        = 1'b0;
  logic        gmask      = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [7:0]  wdata      = 8'h00;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [7:0]  rdata;
  logic        req;
  logic        pin;
  logic [15:0] vhi;
  logic [15:0] vlo;
  logic        rd_seen    = 1'b0;
  logic [7:0]  exp_note;
  logic [7:0]  notes[$];
  logic [31:0] seed       = 32'h0001_2e4e;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  irq_pin_source i_src (.low_req_in(low_req), .irq_n_out(irq_n));

  external_interrupt_pin_latch i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .irq_n_in(irq_n),
    .vector_fetch_in(vfetch), .break_state_in(brk), .break_clear_enable_in(bce),
    .global_int_mask_in(gmask), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .int_request_out(req),
    .pin_level_out(pin), .vector_high_addr_out(vhi), .vector_low_addr_out(vlo)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  always #2.5 clk_sys_in = ~clk_sys_in;

  // The run needs well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys_in) begin
    cycles++;
    rd_seen <= rd;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  // Read data stand only in the cycle after the strobe, so look mid-cycle there.
  always @(negedge clk_sys_in) begin
    if (rd_seen) begin
      exp_note = notes.pop_front();
      `CHK(rdata, exp_note)
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    notes.push_back(e);
    @(posedge clk_sys_in);
    rd   <= 1'b0;
  endtask : rd_reg

  // Write then read with no gap between the strobes.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr    <= 1'b0;
    rd    <= 1'b1;
    notes.push_back(e);
    @(posedge clk_sys_in);
    rd    <= 1'b0;
  endtask : wr_rd

  task automatic pin_to(input logic low, input int n);
    @(posedge clk_sys_in);
    low_req <= low;
    repeat (n) @(posedge clk_sys_in);
  endtask : pin_to

  task automatic fetch();
    @(posedge clk_sys_in);
    vfetch <= 1'b1;
    @(posedge clk_sys_in);
    vfetch <= 1'b0;
  endtask : fetch

  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd_reg(8'h00, 8'h00);
    #1;
    `CHK(vhi, 16'hfffa)
    `CHK(vlo, 16'hfffb)
    `CHK(pin, 1'b1)
    pin_to(1'b1, 4);
    #1;
    `CHK(req, 1'b1)
    `CHK(pin, 1'b0)
    rd_reg(8'h00, 8'h08);
    // Software masks inside its routine, which also exercises the mask field.
    wr_reg(8'h00, 8'h02);
    #1;
    `CHK(req, 1'b0)
    rd_reg(8'h00, 8'h0a);
    wr_reg(8'h00, 8'h00);
    gmask <= 1'b1;
    #1;
    `CHK(req, 1'b0)
    @(posedge clk_sys_in);
    gmask <= 1'b0;
    #1;
    `CHK(req, 1'b1)
    wr_reg(8'h00, 8'h04);
    rd_reg(8'h00, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    rd_reg(8'h00, 8'h00);
    pin_to(1'b0, 4);
    pin_to(1'b1, 4);
    rd_reg(8'h00, 8'h08);
    fetch();
    rd_reg(8'h00, 8'h00);
    pin_to(1'b0, 4);
    wr_reg(8'h00, 8'h01);
    pin_to(1'b1, 4);
    wr_reg(8'h00, 8'h05);
    rd_reg(8'h00, 8'h09);
    pin_to(1'b0, 4);
    rd_reg(8'h00, 8'h01);
    pin_to(1'b1, 4);
    pin_to(1'b0, 4);
    rd_reg(8'h00, 8'h09);
    fetch();
    rd_reg(8'h00, 8'h01);
    wr_reg(8'h00, 8'h00);
    pin_to(1'b1, 4);
    brk <= 1'b1;
    wr_reg(8'h00, 8'h04);
    rd_reg(8'h00, 8'h08);
    bce <= 1'b1;
    wr_reg(8'h00, 8'h04);
    rd_reg(8'h00, 8'h00);
    brk <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd_reg(8'h00, 8'h00);
    bce <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr_reg(seed[7:0] | 8'h01, seed[15:8]);
      rd_reg(seed[23:16] | 8'h01, 8'h00);
      rd_reg(8'h00, 8'h00);
    end
    // Level sensitivity latches a pin that is already low, with no edge.
    wr_rd(8'h00, 8'h01, 8'h01);
    rd_reg(8'h00, 8'h09);
    #1;
    `CHK(req, 1'b1)
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    #1;
    `CHK(req, 1'b0)
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    // The pin stays low through and after reset and must not be taken as an edge.
    repeat (6) @(posedge clk_sys_in);
    #1;
    `CHK(req, 1'b0)
    rd_reg(8'h00, 8'h00);
    low_req <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    print_verdict();
  end
endmodule : test_external_interrupt_pin_latch

`default_nettype wire
